//--- bench/compare_channel_simple_pwm_tb.sv
// Purpose: Self-checking bench for the compare channel in PWM modes
// Assumes: Channel 1, so fault a is the assigned fault input
// Notes:   Duty is judged by low and rising counts over whole periods, phase free
`timescale 1ns/1ps
module compare_channel_simple_pwm_tb import cps_pkg::*; ;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        fault_req = 1'b0;
  logic        fault_b_n = 1'b1;
  logic        cpu_sleep = 1'b0;
  logic        cpu_idle = 1'b0;
  logic        fault_a_n, pin_o, pin_oe, irq, pin_level;
  logic [31:0] rq;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          seed = 17;
  int          cyc = 0;
  int          cp[4] = '{5, 5, 5, 0};
  int          cd[4] = '{0, 5, 6, 0};

  cps_channel #(.CHAN_NUM(1)) u_cps_channel (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hf), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fault_input_a_n(fault_a_n),
    .fault_input_b_n(fault_b_n), .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle),
    .pwm_output_pin_o(pin_o), .pwm_output_pin_oe(pin_oe), .irq(irq));
  cps_load u_cps_load (.pin_o(pin_o), .pin_oe(pin_oe), .fault_req(fault_req), .pin_level(pin_level),
    .fault_a_n(fault_a_n));

  always #2 clk_sys = ~clk_sys;

  task automatic conclude;
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // Request held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rq = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("readdata", e, rq);
  endtask : rdc

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_n

  function automatic int lows(input int p, input int d);
    if (d == 0) return p + 1;
    if (d > p) return 0;
    return p - d + 1;
  endfunction : lows

  task automatic measure(input int p, input int d);
    int lo = 0;
    int ri = 0;
    int el;
    logic prev;
    el = lows(p, d);
    wait_n(2 * (p + 1) + 4);
    prev = pin_level;
    repeat (3 * (p + 1)) begin
      wait_n(1);
      lo += (pin_level === 1'b0);
      ri += (pin_level === 1'b1 && prev === 1'b0);
      prev = pin_level;
    end
    chk("low cycles", 3 * el, lo);
    chk("rising edges", (el > 0 && el < p + 1) ? 3 : 0, ri);
  endtask : measure

  // Active duty loaded with the mode off, before enabling
  task automatic setup(input int p, input int d, input logic [2:0] m, input logic t);
    wr(CPS_ADDR_CTRL, 32'h0);
    wr(CPS_ADDR_TCTL, 32'h0);
    wr(t ? CPS_ADDR_T1CNT : CPS_ADDR_T0CNT, 32'h0);
    wr(t ? CPS_ADDR_T1PER : CPS_ADDR_T0PER, p);
    wr(CPS_ADDR_DACT, d);
    wr(CPS_ADDR_DBUF, d);
    wr(CPS_ADDR_CTRL, {28'h0, t, m});
    wait_n(2);
    chk("pin after enable", d != 0, pin_level);
    wr(CPS_ADDR_TCTL, t ? 32'h2 : 32'h1);
  endtask : setup

  initial begin
    int p, d, tg;
    logic pl;
    wait_n(5);
    chk("waitrequest in reset", 1, avs_waitrequest);
    chk("oe in reset", 0, pin_oe);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    rdc(CPS_ADDR_CTRL, 32'h0);
    rdc(6'h3c, 32'h0);
    for (int i = 0; i < 14; i++) begin
      p = (i < 4) ? cp[i] : ($random(seed) & 32'hf) + 1;
      d = (i < 4) ? cd[i] : ($random(seed) & 32'h7fff) % (p + 3);
      setup(p, d, i[0] ? CPS_MODE_PWMFLT : CPS_MODE_PWM, i[1]);
      measure(p, d);
    end
    setup(9, 4, CPS_MODE_PWM, 1'b0);
    wr(CPS_ADDR_DACT, 32'h2);
    rdc(CPS_ADDR_DACT, 32'h4);
    wr(CPS_ADDR_DBUF, 32'h7);
    measure(9, 7);
    wr(CPS_ADDR_DBUF, 32'h0);
    measure(9, 0);
    wr(CPS_ADDR_DBUF, 32'h4);
    measure(9, 4);
    @(posedge clk_sys);
    cpu_idle <= 1'b1;
    measure(9, 4);
    wr(CPS_ADDR_CTRL, 32'h0000_2006);
    wait_n(2);
    tg = 0;
    pl = pin_level;
    repeat (30) begin
      wait_n(1);
      tg += (pin_level !== pl);
      pl = pin_level;
    end
    chk("toggles while idle halted", 0, tg);
    @(posedge clk_sys);
    cpu_idle <= 1'b0;
    setup(9, 4, CPS_MODE_PWMFLT, 1'b0);
    wr(CPS_ADDR_IEN, 32'h1);
    fault_b_n <= 1'b0;
    wait_n(4);
    chk("oe with other fault input", 1, pin_oe);
    @(posedge clk_sys);
    fault_b_n <= 1'b1;
    cpu_sleep <= 1'b1;
    @(posedge clk_sys);
    // Raised just after an edge: only an unclocked path can act before the next one
    fault_req <= 1'b1;
    #0.5;
    chk("oe on fault", 0, pin_oe);
    chk("pin level on fault", 0, pin_level);
    @(posedge clk_sys);
    cpu_sleep <= 1'b0;
    wait_n(6);
    bus(1'b0, CPS_ADDR_FLAGS, 32'h0);
    chk("compare flag", 1, rq[0]);
    chk("wrap flags", 3, rq[2:1]);
    chk("irq on fault", 1, irq);
    rdc(CPS_ADDR_CTRL, 32'h17);
    wr(CPS_ADDR_CTRL, 32'h7);
    wait_n(3);
    chk("oe while fault held", 0, pin_oe);
    @(posedge clk_sys);
    fault_req <= 1'b0;
    wait_n(6);
    chk("oe before rewrite", 0, pin_oe);
    rdc(CPS_ADDR_CTRL, 32'h17);
    wr(CPS_ADDR_CTRL, 32'h7);
    wait_n(2);
    chk("oe after rewrite", 1, pin_oe);
    rdc(CPS_ADDR_CTRL, 32'h7);
    wr(CPS_ADDR_FLAGS, 32'h1);
    wait_n(3);
    chk("irq after clear", 0, irq);
    measure(9, 4);
    wr(CPS_ADDR_CTRL, 32'h5);
    wait_n(2);
    chk("oe in other mode", 0, pin_oe);
    conclude();
  end
endmodule : compare_channel_simple_pwm_tb

//--- bench/cps_load.sv
// Purpose: Load on the PWM pin and source of fault a
// Assumes: Pin has a pull-down, fault line idles high
// Notes:   Tri-state reads as the pull level, never the last driven value
`timescale 1ns/1ps
module cps_load (
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic fault_req,
  output logic      pin_level,
  output logic      fault_a_n
);
  assign pin_level = pin_oe ? pin_o : 1'b0;
  assign fault_a_n = ~fault_req;
endmodule : cps_load

//--- design/cps_channel.sv
// Purpose: One output compare channel in simple PWM modes with two time bases
// Assumes: Fault inputs are active low; bus master holds requests until waitrequest low
// Notes:   Every bus access takes exactly two cycles (one wait state)
`timescale 1ns/1ps

// Behaviour
// - Modes 110 and 111 select simple PWM
// - Mode 111 adds fault input monitoring
// - Fault a serves channels 1-4, b channel 5
// - Low fault tri-states output asynchronously, immediately
// - Tri-state holds until fault clear and mode rewrite
// - Fault sets compare flag, interrupt when enabled
// - Fault status bit 4, cleared by removal plus rewrite
// - Fault keeps output control in sleep, idle
// - Count equal period wraps to zero next count
// - Period match drives high unless buffered duty zero
// - Buffered duty copied to active at period match
// - Count equal active duty drives output low
// - Active duty read-only in PWM modes
// - Period value N gives N+1 counts
// - Active duty zero keeps output low
// - Duty above period keeps output high
// - Duty equal period: one low count
// - Entering PWM: low if duty zero, else high
// - After first duty match, low until wrap
// - Duty and period both zero: output low
// - Control bit 13 halts channel in idle
module cps_channel
  import cps_pkg::*;
#(
  parameter int unsigned CHAN_NUM = 1
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [5:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [3:0]        avs_byteenable,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              fault_input_a_n,
  input  wire logic              fault_input_b_n,
  input  wire logic              cpu_sleep,
  input  wire logic              cpu_idle,
  output logic                   pwm_output_pin_o,
  output logic                   pwm_output_pin_oe,
  output logic                   irq
);

  cps_req_t           req;
  logic               wait_r;
  logic [31:0]        rdata_r;
  logic               acc;
  logic               wr;
  logic [31:0]        rd_mux;
  cps_ctrl_t          ctrl_r;
  logic [CPS_DW-1:0]  dbuf_r;
  logic [CPS_DW-1:0]  dact_r;
  logic [CPS_DW-1:0]  tb_cnt_r [2];
  logic [CPS_DW-1:0]  tb_per_r [2];
  logic [1:0]         tb_run_r;
  logic [1:0]         tb_wrap;
  logic [1:0]         tb_flag_r;
  logic               cmp_flag_r;
  logic               cmp_ien_r;
  logic               irq_r;
  logic               pin_r;
  logic               oe_r;
  logic               flt_stat_r;
  logic               flt_meta_r;
  logic               flt_sync_r;
  logic               flt_seen_r;

  // Register-bus datapath
  assign req = '{read: avs_read, write: avs_write, address: avs_address,
                 byteenable: avs_byteenable, writedata: avs_writedata};
  assign acc = (req.read | req.write) & ~wait_r;
  assign wr  = req.write & ~wait_r;

  wire wr_ctrl  = wr & (req.address == CPS_ADDR_CTRL);
  wire wr_dbuf  = wr & (req.address == CPS_ADDR_DBUF);
  wire wr_dact  = wr & (req.address == CPS_ADDR_DACT);
  wire wr_tctl  = wr & (req.address == CPS_ADDR_TCTL);
  wire wr_flags = wr & (req.address == CPS_ADDR_FLAGS);
  wire wr_ien   = wr & (req.address == CPS_ADDR_IEN);
  wire [1:0] wr_tcnt = {wr & (req.address == CPS_ADDR_T1CNT), wr & (req.address == CPS_ADDR_T0CNT)};
  wire [1:0] wr_tper = {wr & (req.address == CPS_ADDR_T1PER), wr & (req.address == CPS_ADDR_T0PER)};

  function automatic logic [CPS_DW-1:0] merge16(input logic [CPS_DW-1:0] old_v,
                                                input logic [31:0] wd, input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old_v[15:8], be[0] ? wd[7:0] : old_v[7:0]};
  endfunction : merge16

  wire [CPS_DW-1:0] wd16 = merge16(CPS_ZERO16, req.writedata, req.byteenable);

  // Control write decode
  wire [2:0] new_mode   = req.byteenable[0] ? req.writedata[CPS_CTRL_MODE_LSB +: 3]
                                            : ctrl_r.operating_mode_field;
  wire       new_tsel   = req.byteenable[0] ? req.writedata[CPS_CTRL_TSEL_BIT] : ctrl_r.tsel;
  wire       new_idle   = req.byteenable[1] ? req.writedata[CPS_CTRL_IDLE_BIT] : ctrl_r.idle_halt_select;
  wire       mode_pwm   = (ctrl_r.operating_mode_field == CPS_MODE_PWM) |
                          (ctrl_r.operating_mode_field == CPS_MODE_PWMFLT);
  wire       mode_flt   = ctrl_r.operating_mode_field == CPS_MODE_PWMFLT;
  wire       new_pwm    = (new_mode == CPS_MODE_PWM) | (new_mode == CPS_MODE_PWMFLT);
  wire       new_flt    = new_mode == CPS_MODE_PWMFLT;

  // Fault input routing by channel number
  wire fault_pin_n = (CHAN_NUM <= CPS_FLTA_LAST_CH) ? fault_input_a_n : fault_input_b_n;

  // Raw pin and mode bit only; the kill path must not wait for a clock edge
  wire kill_n = ~(mode_flt & ~fault_pin_n);

  // Halt in sleep always, in idle when selected
  wire halt = cpu_sleep | (cpu_idle & ctrl_r.idle_halt_select);

  // Time bases
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tb
      assign tb_wrap[gi] = tb_run_r[gi] & ~halt & (tb_cnt_r[gi] == tb_per_r[gi]);
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          tb_cnt_r[gi]  <= CPS_ZERO16;
          tb_per_r[gi]  <= CPS_ZERO16;
          tb_flag_r[gi] <= 1'b0;
        end else begin
          if (wr_tcnt[gi])
            tb_cnt_r[gi] <= merge16(tb_cnt_r[gi], req.writedata, req.byteenable);
          else if (tb_wrap[gi])
            tb_cnt_r[gi] <= CPS_ZERO16;
          else if (tb_run_r[gi] & ~halt)
            tb_cnt_r[gi] <= tb_cnt_r[gi] + 16'h0001;
          if (wr_tper[gi])
            tb_per_r[gi] <= merge16(tb_per_r[gi], req.writedata, req.byteenable);
          // Set wins over a same-cycle clear
          if (tb_wrap[gi])
            tb_flag_r[gi] <= 1'b1;
          else if (wr_flags & req.byteenable[0] & req.writedata[CPS_FLG_TB0_BIT + gi])
            tb_flag_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Selected time base
  wire              s_tick = tb_run_r[ctrl_r.tsel] & ~halt;
  wire              s_wrap = tb_wrap[ctrl_r.tsel];
  wire [CPS_DW-1:0] s_next = tb_cnt_r[ctrl_r.tsel] + 16'h0001;
  // Match on the count about to be shown, so the pin level tracks the count
  wire              d_match = s_tick & ~s_wrap & (s_next == dact_r);
  wire              enter   = wr_ctrl & new_pwm;

  // Control, duty and flag registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r     <= '{idle_halt_select: 1'b0, tsel: 1'b0, operating_mode_field: CPS_MODE_OFF};
      dbuf_r     <= CPS_ZERO16;
      dact_r     <= CPS_ZERO16;
      tb_run_r   <= 2'h0;
      cmp_ien_r  <= 1'b0;
      cmp_flag_r <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      if (wr_ctrl)
        ctrl_r <= '{idle_halt_select: new_idle, tsel: new_tsel, operating_mode_field: new_mode};
      if (wr_dbuf)
        dbuf_r <= merge16(dbuf_r, req.writedata, req.byteenable);
      if (mode_pwm & ~halt & s_wrap)
        dact_r <= dbuf_r;
      else if (wr_dact & ~mode_pwm)
        dact_r <= merge16(dact_r, req.writedata, req.byteenable);
      if (wr_tctl & req.byteenable[0])
        tb_run_r <= req.writedata[1:0];
      if (wr_ien & req.byteenable[0])
        cmp_ien_r <= req.writedata[CPS_IEN_CMP_BIT];
      if (mode_flt & flt_seen_r & ~flt_sync_r)
        cmp_flag_r <= cmp_flag_r;
      if (mode_flt & ~flt_sync_r & ~flt_seen_r)
        cmp_flag_r <= 1'b1;
      else if (wr_flags & req.byteenable[0] & req.writedata[CPS_FLG_CMP_BIT])
        cmp_flag_r <= 1'b0;
      irq_r <= cmp_flag_r & cmp_ien_r;
    end
  end

  // Fault synchroniser; only the second stage is looked at
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flt_meta_r <= 1'b1;
      flt_sync_r <= 1'b1;
      flt_seen_r <= 1'b0;
    end else begin
      flt_meta_r <= fault_pin_n;
      flt_sync_r <= flt_meta_r;
      flt_seen_r <= mode_flt & ~flt_sync_r;
    end
  end

  // Pin level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      pin_r <= 1'b0;
    else if (enter)
      pin_r <= dact_r != CPS_ZERO16;
    else if (~mode_pwm | halt)
      pin_r <= pin_r;
    else if (s_wrap)
      pin_r <= dbuf_r != CPS_ZERO16;
    else if (d_match)
      pin_r <= 1'b0;
  end

  // Output enable and fault status share the asynchronous kill.
  // Trade-off: kill_n mixes a register bit and a raw pin, so a glitch on
  // the fault pin also shuts the output; that is the safe direction.
  wire oe_keep    = oe_r & mode_pwm;
  wire oe_nxt     = wr_ctrl ? (new_pwm & (~new_flt | flt_sync_r)) : oe_keep;
  wire flt_st_nxt = (wr_ctrl & flt_sync_r) ? 1'b0 : flt_stat_r;

  always_ff @(posedge clk_sys or negedge rst_n or negedge kill_n) begin
    if (!rst_n) begin
      oe_r       <= 1'b0;
      flt_stat_r <= 1'b0;
    end else if (!kill_n) begin
      oe_r       <= 1'b0;
      flt_stat_r <= 1'b1;
    end else begin
      oe_r       <= oe_nxt;
      flt_stat_r <= flt_st_nxt;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = CPS_ZERO32;
    case (req.address)
      CPS_ADDR_CTRL: begin
        rd_mux[CPS_CTRL_MODE_LSB +: 3]  = ctrl_r.operating_mode_field;
        rd_mux[CPS_CTRL_TSEL_BIT]       = ctrl_r.tsel;
        rd_mux[CPS_CTRL_FLT_BIT]        = flt_stat_r;
        rd_mux[CPS_CTRL_IDLE_BIT]       = ctrl_r.idle_halt_select;
      end
      CPS_ADDR_DBUF:  rd_mux[CPS_DW-1:0] = dbuf_r;
      CPS_ADDR_DACT:  rd_mux[CPS_DW-1:0] = dact_r;
      CPS_ADDR_T0CNT: rd_mux[CPS_DW-1:0] = tb_cnt_r[0];
      CPS_ADDR_T0PER: rd_mux[CPS_DW-1:0] = tb_per_r[0];
      CPS_ADDR_T1CNT: rd_mux[CPS_DW-1:0] = tb_cnt_r[1];
      CPS_ADDR_T1PER: rd_mux[CPS_DW-1:0] = tb_per_r[1];
      CPS_ADDR_TCTL:  rd_mux[1:0] = tb_run_r;
      CPS_ADDR_FLAGS: begin
        rd_mux[CPS_FLG_CMP_BIT] = cmp_flag_r;
        rd_mux[CPS_FLG_TB0_BIT] = tb_flag_r[0];
        rd_mux[CPS_FLG_TB1_BIT] = tb_flag_r[1];
      end
      CPS_ADDR_IEN:   rd_mux[CPS_IEN_CMP_BIT] = cmp_ien_r;
      default:        rd_mux = CPS_ZERO32;
    endcase
  end

  // One wait state: first cycle of a request has waitrequest high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_r  <= 1'b1;
      rdata_r <= CPS_ZERO32;
    end else begin
      wait_r  <= ~((req.read | req.write) & wait_r);
      if (req.read & wait_r)
        rdata_r <= rd_mux;
    end
  end

  assign avs_waitrequest   = wait_r;
  assign avs_readdata      = rdata_r;
  assign pwm_output_pin_o  = pin_r;
  assign pwm_output_pin_oe = oe_r;
  assign irq               = irq_r;

  wire unused_ok = &{1'b0, acc, wd16};

  // Checks
  property p_mode_enable;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_ctrl & ~new_pwm |=> ~mode_pwm & ~oe_r;
  endproperty
  a_mode_enable: assert property (p_mode_enable) else $error("output enabled outside PWM modes");

  // Kill sampled high, so no fault can hold the enable down
  property p_oe_enter;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_ctrl & (new_mode == CPS_MODE_PWM) & kill_n |=> oe_r;
  endproperty
  a_oe_enter: assert property (p_oe_enter) else $error("output not enabled on PWM entry");

  property p_wrap;
    @(posedge clk_sys) disable iff (!rst_n)
    tb_wrap[0] & ~wr_tcnt[0] |=> tb_cnt_r[0] == CPS_ZERO16;
  endproperty
  a_wrap: assert property (p_wrap) else $error("time base did not wrap to zero");

  property p_fault_kill;
    @(posedge clk_sys) disable iff (!rst_n)
    mode_flt & ~fault_pin_n |-> ~oe_r & flt_stat_r;
  endproperty
  a_fault_kill: assert property (p_fault_kill) else $error("fault did not tri-state output");

  property p_fault_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    ~oe_r & flt_stat_r & ~wr_ctrl |=> ~oe_r;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("output re-enabled without mode rewrite");

  property p_fault_flag;
    @(posedge clk_sys) disable iff (!rst_n)
    mode_flt & ~fault_pin_n & ~wr_ctrl ##1 ~fault_pin_n & ~wr_ctrl |-> ##[1:3] cmp_flag_r;
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("fault did not set compare flag");

  property p_flt_stat;
    @(posedge clk_sys) disable iff (!rst_n)
    flt_stat_r & ~wr_ctrl |=> flt_stat_r;
  endproperty
  a_flt_stat: assert property (p_flt_stat) else $error("fault status cleared without rewrite");

  property p_period_high;
    @(posedge clk_sys) disable iff (!rst_n)
    mode_pwm & ~halt & s_wrap & ~enter |=> pin_r == (dact_r != CPS_ZERO16);
  endproperty
  a_period_high: assert property (p_period_high) else $error("wrong level after period match");

  property p_act_stable;
    @(posedge clk_sys) disable iff (!rst_n)
    mode_pwm & ~s_wrap |=> $stable(dact_r);
  endproperty
  a_act_stable: assert property (p_act_stable) else $error("active duty changed off period match");

  property p_duty_low;
    @(posedge clk_sys) disable iff (!rst_n)
    mode_pwm & d_match & ~enter |=> ~pin_r;
  endproperty
  a_duty_low: assert property (p_duty_low) else $error("duty match did not drive low");

  // Count above period is legal after a period rewrite; excluded here
  property p_full_high;
    @(posedge clk_sys) disable iff (!rst_n)
    mode_pwm & pin_r & ~wr_ctrl & (dact_r > tb_per_r[ctrl_r.tsel]) & (dbuf_r != CPS_ZERO16) &
    (tb_cnt_r[ctrl_r.tsel] <= tb_per_r[ctrl_r.tsel]) |=> pin_r;
  endproperty
  a_full_high: assert property (p_full_high) else $error("full duty output went low");

  property p_zero_low;
    @(posedge clk_sys) disable iff (!rst_n)
    mode_pwm & ~pin_r & ~wr_ctrl & (dact_r == CPS_ZERO16) & (dbuf_r == CPS_ZERO16) |=> ~pin_r;
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("zero duty output went high");

  property p_enter;
    @(posedge clk_sys) disable iff (!rst_n)
    enter |=> pin_r == ($past(dact_r) != CPS_ZERO16);
  endproperty
  a_enter: assert property (p_enter) else $error("wrong initial level on PWM entry");

  property p_halt;
    @(posedge clk_sys) disable iff (!rst_n)
    halt & ~wr_tcnt[ctrl_r.tsel] & ~enter |=> $stable(pin_r) && $stable(tb_cnt_r[0]);
  endproperty
  a_halt: assert property (p_halt) else $error("channel ran while halted");

  c_fault:  cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(flt_stat_r));
  c_full:   cover property (@(posedge clk_sys) disable iff (!rst_n) (mode_pwm & pin_r) [*8]);
  c_cycle:  cover property (@(posedge clk_sys) disable iff (!rst_n) mode_pwm & d_match ##[1:40] s_wrap);
  c_rewrt:  cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(flt_stat_r) ##1 oe_r);

endmodule : cps_channel

//--- design/cps_pkg.sv
// Purpose: Shared constants and types for the compare channel PWM block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per register
// Notes:   Duty and time base registers are 16 bits wide, low half of the word
package cps_pkg;

  localparam int unsigned CPS_AW       = 6;
  localparam int unsigned CPS_DW       = 16;

  // Register byte addresses
  localparam logic [5:0] CPS_ADDR_CTRL  = 6'h00;
  localparam logic [5:0] CPS_ADDR_DBUF  = 6'h04;
  localparam logic [5:0] CPS_ADDR_DACT  = 6'h08;
  localparam logic [5:0] CPS_ADDR_T0CNT = 6'h0c;
  localparam logic [5:0] CPS_ADDR_T0PER = 6'h10;
  localparam logic [5:0] CPS_ADDR_T1CNT = 6'h14;
  localparam logic [5:0] CPS_ADDR_T1PER = 6'h18;
  localparam logic [5:0] CPS_ADDR_TCTL  = 6'h1c;
  localparam logic [5:0] CPS_ADDR_FLAGS = 6'h20;
  localparam logic [5:0] CPS_ADDR_IEN   = 6'h24;

  // Control register fields
  localparam int unsigned CPS_CTRL_MODE_LSB = 0;
  localparam int unsigned CPS_CTRL_TSEL_BIT = 3;
  localparam int unsigned CPS_CTRL_FLT_BIT  = 4;
  localparam int unsigned CPS_CTRL_IDLE_BIT = 13;

  // Flag register fields (write one to clear), then the interrupt enable bit
  localparam int unsigned CPS_FLG_CMP_BIT = 0;
  localparam int unsigned CPS_FLG_TB0_BIT = 1;
  localparam int unsigned CPS_FLG_TB1_BIT = 2;
  localparam int unsigned CPS_IEN_CMP_BIT = 0;

  // Channel operating modes
  localparam logic [2:0] CPS_MODE_OFF    = 3'h0;
  localparam logic [2:0] CPS_MODE_PWM    = 3'h6;
  localparam logic [2:0] CPS_MODE_PWMFLT = 3'h7;

  // Highest channel number served by fault input a
  localparam int unsigned CPS_FLTA_LAST_CH = 4;

  localparam logic [CPS_DW-1:0] CPS_ZERO16 = 16'h0000;
  localparam logic [31:0]       CPS_ZERO32 = 32'h0000_0000;

  typedef struct packed {
    logic       idle_halt_select;
    logic       tsel;
    logic [2:0] operating_mode_field;
  } cps_ctrl_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } cps_req_t;

endpackage : cps_pkg
